// ===== hw/rhs_pkg.sv
// constants for the root hub status and port power registers
package rhs_pkg;
    // command codes on the processor bus
    localparam logic [7:0] RHS_RD_HUB = 8'h14;
    localparam logic [7:0] RHS_WR_HUB = 8'h94;
    localparam logic [7:0] RHS_RD_PORT1 = 8'h15;
    localparam logic [7:0] RHS_RD_PORT2 = 8'h16;
    localparam logic [7:0] RHS_WR_PORT1 = 8'h95;
    localparam logic [7:0] RHS_WR_PORT2 = 8'h96;

    localparam int RHS_NPORTS = 2;
    localparam logic [31:0] RHS_RESET_VAL = 32'h0000_0000;

    // hub_status_power fields
    localparam int RHS_HUB_WAKE_CLR = 31;
    localparam int RHS_HUB_OC_CHG = 17;
    localparam int RHS_HUB_GLOB_ON = 16;
    localparam int RHS_HUB_WAKE_EN = 15;
    localparam int RHS_HUB_OC_IND = 1;
    localparam int RHS_HUB_GLOB_OFF = 0;

    // port_status_control status fields (low word)
    localparam int RHS_P_CONNECT = 0;
    localparam int RHS_P_ENABLE = 1;
    localparam int RHS_P_SUSPEND = 2;
    localparam int RHS_P_OC = 3;
    localparam int RHS_P_RESET = 4;
    localparam int RHS_P_POWER = 8;
    localparam int RHS_P_LOWSPD = 9;
    // port write command bits
    localparam int RHS_PW_CLR_EN = 0;
    localparam int RHS_PW_SET_EN = 1;
    localparam int RHS_PW_SET_SUSP = 2;
    localparam int RHS_PW_CLR_SUSP = 3;
    localparam int RHS_PW_SET_RST = 4;
    localparam int RHS_PW_SET_PWR = 8;
    localparam int RHS_PW_CLR_PWR = 9;
    // port change fields (high word)
    localparam int RHS_P_CONNECT_CHG = 16;
    localparam int RHS_P_ENABLE_CHG = 17;
    localparam int RHS_P_SUSPEND_CHG = 18;
    localparam int RHS_P_OC_CHG = 19;
    localparam int RHS_P_RESET_CHG = 20;
endpackage : rhs_pkg

// ===== hw/rhs_port_regs.sv
// one downstream port status and control register
`timescale 1ns/1ps
module rhs_port_regs
    import rhs_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // commands in, status out
    rhs_port_if.port port_if
);
    logic pend_q, pend_d;
    logic [31:0] wbuf_q, wbuf_d;
    logic conn_q, conn_d, en_q, en_d, susp_q, susp_d, resetting_q, resetting_d;
    logic oc_q, oc_d, pwr_q, pwr_d, lowspd_q, lowspd_d;
    logic conn_chg_q, conn_chg_d, en_chg_q, en_chg_d, susp_chg_q, susp_chg_d;
    logic oc_chg_q, oc_chg_d, rst_chg_q, rst_chg_d;
    logic apply;
    logic [31:0] w;
    logic conn_chg_set, en_chg_set, susp_chg_set, oc_chg_set, rst_chg_set;

    always_comb begin
        apply = pend_q & ~port_if.busy; // R16
        w = apply ? wbuf_q : 32'h0000_0000;
        // a newer write replaces one still waiting for the bus
        pend_d = port_if.wr | (pend_q & ~apply); // R16
        wbuf_d = port_if.wr ? port_if.wdata : wbuf_q;
        conn_d = port_if.connect;
        lowspd_d = port_if.low_speed & port_if.connect;
        oc_d = port_if.oc;
        conn_chg_set = conn_d != conn_q;
        oc_chg_set = oc_d != oc_q;
        pwr_d = pwr_q;
        if (w[RHS_PW_SET_PWR] | port_if.glob_on) begin
            pwr_d = 1'b1;
        end
        // off beats on so a power-off command wins over a power-on in the same cycle
        if (w[RHS_PW_CLR_PWR] | port_if.glob_off) begin
            pwr_d = 1'b0;
        end
        en_d = en_q;
        en_chg_set = 1'b0;
        if (w[RHS_PW_SET_EN] & conn_q) begin
            en_d = 1'b1;
        end
        if (w[RHS_PW_CLR_EN]) begin
            en_d = 1'b0;
        end
        // only hardware-caused disables flag a change
        if (en_q & (~port_if.connect | (port_if.oc & ~oc_q))) begin
            en_d = 1'b0;
            en_chg_set = 1'b1;
        end
        susp_d = susp_q;
        susp_chg_set = 1'b0;
        if (w[RHS_PW_SET_SUSP] & en_q) begin
            susp_d = 1'b1;
        end
        if (susp_q & port_if.resume_done) begin
            susp_d = 1'b0;
            susp_chg_set = 1'b1;
        end
        resetting_d = resetting_q;
        rst_chg_set = 1'b0;
        if (w[RHS_PW_SET_RST] & conn_q) begin
            resetting_d = 1'b1;
        end
        if (resetting_q & port_if.reset_done) begin
            resetting_d = 1'b0;
            en_d = 1'b1;
            rst_chg_set = 1'b1;
        end
        // change flags: write 1 clears, a new event wins over the clear
        conn_chg_d = conn_chg_set | (conn_chg_q & ~w[RHS_P_CONNECT_CHG]); // R19
        en_chg_d = en_chg_set | (en_chg_q & ~w[RHS_P_ENABLE_CHG]); // R19
        oc_chg_d = oc_chg_set | (oc_chg_q & ~w[RHS_P_OC_CHG]); // R19
        rst_chg_d = rst_chg_set | (rst_chg_q & ~w[RHS_P_RESET_CHG]); // R19
        susp_chg_d = susp_chg_set | (susp_chg_q & ~w[RHS_P_SUSPEND_CHG]); // R19
        if (rst_chg_set) begin
            susp_chg_d = 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pend_q <= 1'b0;
            wbuf_q <= RHS_RESET_VAL;
            {conn_q, en_q, susp_q, resetting_q, oc_q, pwr_q, lowspd_q} <= 7'h00;
            {conn_chg_q, en_chg_q, susp_chg_q, oc_chg_q, rst_chg_q} <= 5'h00; // R19
        end else begin
            pend_q <= pend_d;
            wbuf_q <= wbuf_d;
            {conn_q, en_q, susp_q, resetting_q, oc_q, pwr_q, lowspd_q} <=
                {conn_d, en_d, susp_d, resetting_d, oc_d, pwr_d, lowspd_d};
            {conn_chg_q, en_chg_q, susp_chg_q, oc_chg_q, rst_chg_q} <=
                {conn_chg_d, en_chg_d, susp_chg_d, oc_chg_d, rst_chg_d};
        end
    end

    always_comb begin
        port_if.status = 32'h0000_0000;
        port_if.status[RHS_P_CONNECT] = conn_q; // R15
        port_if.status[RHS_P_ENABLE] = en_q;
        port_if.status[RHS_P_SUSPEND] = susp_q;
        port_if.status[RHS_P_OC] = oc_q;
        port_if.status[RHS_P_RESET] = resetting_q;
        port_if.status[RHS_P_POWER] = pwr_q;
        port_if.status[RHS_P_LOWSPD] = lowspd_q;
        port_if.status[RHS_P_CONNECT_CHG] = conn_chg_q; // R15
        port_if.status[RHS_P_ENABLE_CHG] = en_chg_q;
        port_if.status[RHS_P_SUSPEND_CHG] = susp_chg_q;
        port_if.status[RHS_P_OC_CHG] = oc_chg_q;
        port_if.status[RHS_P_RESET_CHG] = rst_chg_q;
    end

    assign port_if.power = pwr_q;
    assign port_if.connect_chg_set = conn_chg_set;
endmodule : rhs_port_regs

// ===== hw/rhs_root_hub.sv
// root hub status, port power and port status registers
//
// Operation
// R1: writing 1 at bit 31 clears wake enable
// R2: over-current indicator change sets bit 17
// R3: writing 1 at bit 17 clears it
// R4: hub bit 16 always reads zero
// R5: hub bit 0 always reads zero
// R6: global mode: bit 16 powers all ports
// R7: per-port mode: bit 16 powers unmasked ports
// R8: global mode: bit 0 unpowers all ports
// R9: per-port mode: bit 0 unpowers unmasked ports
// R10: wake enabled connect change causes resume
// R11: writing 1 at bit 15 sets wake enable
// R12: global reporting: bit 1 shows over-current
// R13: per-port reporting: bit 1 reads zero
// R14: port registers implemented up to port count
// R15: low word status, high word changes
// R16: port writes wait for running transaction
// R17: software writes zero to reserved bits
// R18: port codes 15H/16H read, 95H/96H write
// R19: change flags bits 20..16, reset zero
// R20: mask bit per port selects per-port control
// R21: over-current inputs synchronised before use
`timescale 1ns/1ps
module rhs_root_hub
    import rhs_pkg::*;
(
    // clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic NRST_IN,
    // processor command port
    input wire logic CMD_VALID_IN,
    input wire logic [7:0] CMD_CODE_IN,
    input wire logic [31:0] CMD_WDATA_IN,
    output logic [31:0] CMD_RDATA_OUT,
    output logic CMD_RDATA_VALID_OUT,
    // configuration from the descriptor registers
    input wire logic [1:0] DOWNSTREAM_PORT_COUNT_IN,
    input wire logic POWER_SWITCHING_SELECT_IN,
    input wire logic [2:0] PER_PORT_POWER_MASK_IN,
    input wire logic GLOBAL_OC_REPORT_IN,
    // usb engine state
    input wire logic XFER_BUSY_IN,
    input wire logic USB_SUSPENDED_IN,
    input wire logic [1:0] PORT_CONNECT_IN,
    input wire logic [1:0] PORT_LOW_SPEED_IN,
    input wire logic [1:0] PORT_RESET_DONE_IN,
    input wire logic [1:0] PORT_RESUME_DONE_IN,
    output logic RESUME_DETECTED_IRQ_OUT,
    // port pins
    input wire logic [1:0] PORT_OC_N_IN,
    output logic [1:0] PORT_POWER_OUT
);
    // over-current synchroniser
    logic [1:0] oc_meta_q, oc_meta_d;
    logic [1:0] oc_sync_q, oc_sync_d;

    // hub register state
    logic wake_en_q, wake_en_d;
    logic oc_ind_q, oc_ind_d;
    logic oc_chg_q, oc_chg_d;
    logic resume_q, resume_d;

    // command decode
    logic hub_wr, hub_rd;
    logic [1:0] port_wr, port_rd;
    logic [1:0] port_present;
    logic glob_on_cmd, glob_off_cmd;
    logic [1:0] port_on, port_off;

    // read path
    logic [31:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] hub_rd_word;
    logic [31:0] port_status [RHS_NPORTS];
    logic [1:0] port_power;
    logic [1:0] conn_chg_set;

    // port presence follows the configured count
    always_comb begin
        port_present[0] = DOWNSTREAM_PORT_COUNT_IN >= 2'h1; // R14
        port_present[1] = DOWNSTREAM_PORT_COUNT_IN >= 2'h2; // R14
    end

    // command decode
    always_comb begin
        hub_wr = CMD_VALID_IN && (CMD_CODE_IN == RHS_WR_HUB);
        hub_rd = CMD_VALID_IN && (CMD_CODE_IN == RHS_RD_HUB);
        port_wr[0] = CMD_VALID_IN && (CMD_CODE_IN == RHS_WR_PORT1) && port_present[0]; // R18
        port_wr[1] = CMD_VALID_IN && (CMD_CODE_IN == RHS_WR_PORT2) && port_present[1]; // R18
        port_rd[0] = CMD_VALID_IN && (CMD_CODE_IN == RHS_RD_PORT1); // R18
        port_rd[1] = CMD_VALID_IN && (CMD_CODE_IN == RHS_RD_PORT2); // R18
        glob_on_cmd = hub_wr & CMD_WDATA_IN[RHS_HUB_GLOB_ON];
        glob_off_cmd = hub_wr & CMD_WDATA_IN[RHS_HUB_GLOB_OFF];
    end

    // global power commands, gated per port by the mask in per-port mode
    always_comb begin
        for (int i = 0; i < RHS_NPORTS; i++) begin
            if (!POWER_SWITCHING_SELECT_IN) begin
                port_on[i] = glob_on_cmd & port_present[i]; // R6
                port_off[i] = glob_off_cmd & port_present[i]; // R8
            end else begin
                port_on[i] = glob_on_cmd & port_present[i] & ~PER_PORT_POWER_MASK_IN[i + 1]; // R7 R20
                port_off[i] = glob_off_cmd & port_present[i] & ~PER_PORT_POWER_MASK_IN[i + 1]; // R9 R20
            end
        end
    end

    // two-flop synchroniser on the active-low over-current pins
    always_comb begin
        oc_meta_d = ~PORT_OC_N_IN; // R21
        oc_sync_d = oc_meta_q; // R21
    end

    always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            oc_meta_q <= 2'h0;
            oc_sync_q <= 2'h0;
        end else begin
            oc_meta_q <= oc_meta_d;
            oc_sync_q <= oc_sync_d;
        end
    end

    // hub-level status next state
    always_comb begin
        // global reporting merges every present port into one indicator
        if (GLOBAL_OC_REPORT_IN) begin
            oc_ind_d = |(oc_sync_q & port_present); // R12
        end else begin
            oc_ind_d = 1'b0; // R13
        end
        // a fresh change wins over a clear in the same cycle
        oc_chg_d = (oc_ind_d != oc_ind_q) | (oc_chg_q & ~(hub_wr & CMD_WDATA_IN[RHS_HUB_OC_CHG])); // R2 R3
        wake_en_d = wake_en_q;
        if (hub_wr & CMD_WDATA_IN[RHS_HUB_WAKE_EN]) begin
            wake_en_d = 1'b1; // R11
        end
        if (hub_wr & CMD_WDATA_IN[RHS_HUB_WAKE_CLR]) begin
            wake_en_d = 1'b0; // R1
        end
        // resume only while suspended and only from a wake-enabled connect change
        resume_d = wake_en_q & USB_SUSPENDED_IN & (|(conn_chg_set & port_present)); // R10
    end

    always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            wake_en_q <= 1'b0;
            oc_ind_q <= 1'b0;
            oc_chg_q <= 1'b0;
            resume_q <= 1'b0;
        end else begin
            wake_en_q <= wake_en_d;
            oc_ind_q <= oc_ind_d;
            oc_chg_q <= oc_chg_d;
            resume_q <= resume_d;
        end
    end

    // read word of the hub register; unsupported local power bits stay zero
    always_comb begin
        hub_rd_word = 32'h0000_0000;
        hub_rd_word[RHS_HUB_OC_CHG] = oc_chg_q;
        hub_rd_word[RHS_HUB_GLOB_ON] = 1'b0; // R4
        hub_rd_word[RHS_HUB_WAKE_EN] = wake_en_q;
        hub_rd_word[RHS_HUB_OC_IND] = oc_ind_q;
        hub_rd_word[RHS_HUB_GLOB_OFF] = 1'b0; // R5
    end

    // per-port registers, each behind its own carrier
    for (genvar g = 0; g < RHS_NPORTS; g++) begin : g_port
        rhs_port_if rhs_port_if_inst ();

        assign rhs_port_if_inst.wr = port_wr[g];
        assign rhs_port_if_inst.wdata = CMD_WDATA_IN;
        assign rhs_port_if_inst.busy = XFER_BUSY_IN;
        assign rhs_port_if_inst.glob_on = port_on[g];
        assign rhs_port_if_inst.glob_off = port_off[g];
        // absent ports see no connect and no fault, so they raise a connect or fault change only in the cycle they drop out
        assign rhs_port_if_inst.connect = PORT_CONNECT_IN[g] & port_present[g];
        assign rhs_port_if_inst.low_speed = PORT_LOW_SPEED_IN[g];
        assign rhs_port_if_inst.oc = oc_sync_q[g] & port_present[g];
        assign rhs_port_if_inst.reset_done = PORT_RESET_DONE_IN[g];
        assign rhs_port_if_inst.resume_done = PORT_RESUME_DONE_IN[g];
        assign port_status[g] = rhs_port_if_inst.status;
        assign port_power[g] = rhs_port_if_inst.power;
        assign conn_chg_set[g] = rhs_port_if_inst.connect_chg_set;

        rhs_port_regs rhs_port_regs_inst (
            .clk_in(CLK_SYS_IN),
            .rst_n_in(NRST_IN),
            .port_if(rhs_port_if_inst.port)
        );
    end

    // read mux; absent ports read as zero
    always_comb begin
        rdata_d = rdata_q;
        rvalid_d = 1'b0;
        if (hub_rd) begin
            rdata_d = hub_rd_word;
            rvalid_d = 1'b1;
        end else if (port_rd[0]) begin
            rdata_d = port_present[0] ? port_status[0] : 32'h0000_0000; // R14
            rvalid_d = 1'b1;
        end else if (port_rd[1]) begin
            rdata_d = port_present[1] ? port_status[1] : 32'h0000_0000; // R14
            rvalid_d = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            rdata_q <= RHS_RESET_VAL;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign CMD_RDATA_OUT = rdata_q;
    assign CMD_RDATA_VALID_OUT = rvalid_q;
    assign RESUME_DETECTED_IRQ_OUT = resume_q;
    assign PORT_POWER_OUT = port_power & port_present;
endmodule : rhs_root_hub

// ===== hw/unused_placeholder_none.sv
// carrier between the hub logic and one port register
`timescale 1ns/1ps
interface rhs_port_if;
    // hub to port
    logic wr;
    logic [31:0] wdata;
    logic busy;
    logic glob_on;
    logic glob_off;
    logic connect;
    logic low_speed;
    logic oc;
    logic reset_done;
    logic resume_done;
    // port to hub
    logic [31:0] status;
    logic power;
    logic connect_chg_set;

    modport hub (
        output wr, wdata, busy, glob_on, glob_off, connect, low_speed, oc, reset_done, resume_done,
        input status, power, connect_chg_set
    );
    modport port (
        input wr, wdata, busy, glob_on, glob_off, connect, low_speed, oc, reset_done, resume_done,
        output status, power, connect_chg_set
    );
endinterface : rhs_port_if

// ===== tb/rhs_root_hub_properties.sv
// concurrent checks on the root hub register ports
`timescale 1ns/1ps
module rhs_root_hub_properties
    import rhs_pkg::*;
(
    // clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic NRST_IN,
    // command port
    input wire logic CMD_VALID_IN,
    input wire logic [7:0] CMD_CODE_IN,
    input wire logic [31:0] CMD_WDATA_IN,
    input wire logic [31:0] CMD_RDATA_OUT,
    input wire logic CMD_RDATA_VALID_OUT,
    // configuration
    input wire logic [1:0] DOWNSTREAM_PORT_COUNT_IN,
    input wire logic POWER_SWITCHING_SELECT_IN,
    input wire logic [2:0] PER_PORT_POWER_MASK_IN,
    input wire logic GLOBAL_OC_REPORT_IN,
    // results
    input wire logic RESUME_DETECTED_IRQ_OUT,
    input wire logic [1:0] PORT_POWER_OUT
);
    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (!NRST_IN);
    logic rd_cmd;
    logic hub_rd;
    logic hub_wr;
    logic pp;
    assign rd_cmd = CMD_VALID_IN && (CMD_CODE_IN == RHS_RD_HUB || CMD_CODE_IN == RHS_RD_PORT1
        || CMD_CODE_IN == RHS_RD_PORT2);
    assign hub_rd = CMD_VALID_IN && CMD_CODE_IN == RHS_RD_HUB;
    // power checks only with both ports present, since absent ports stay off
    assign hub_wr = CMD_VALID_IN && CMD_CODE_IN == RHS_WR_HUB && DOWNSTREAM_PORT_COUNT_IN == 2'h2;
    assign pp = POWER_SWITCHING_SELECT_IN;

    read_answer_a: assert property (rd_cmd |=> CMD_RDATA_VALID_OUT)
        else $error("read command got no answer");
    answer_cause_a: assert property (CMD_RDATA_VALID_OUT |-> $past(rd_cmd))
        else $error("answer without read command");
    hub_zero_bits_a: assert property (hub_rd |=> !CMD_RDATA_OUT[16] && !CMD_RDATA_OUT[0])
        else $error("hub bit 16 or 0 read as one");
    oc_ind_zero_a: assert property (hub_rd && !GLOBAL_OC_REPORT_IN |=> !CMD_RDATA_OUT[1])
        else $error("hub over-current bit set in per-port reporting");
    glob_on_a: assert property (hub_wr && !pp && CMD_WDATA_IN[16] && !CMD_WDATA_IN[0]
        |=> PORT_POWER_OUT == 2'b11)
        else $error("global power on missed a port");
    glob_off_a: assert property (hub_wr && !pp && CMD_WDATA_IN[0] |=> PORT_POWER_OUT == 2'b00)
        else $error("global power off missed a port");
    mask_on_a: assert property (hub_wr && pp && CMD_WDATA_IN[16] && !CMD_WDATA_IN[0]
        && !PER_PORT_POWER_MASK_IN[1] |=> PORT_POWER_OUT[0])
        else $error("unmasked port 1 not powered");
    mask_off_a: assert property (hub_wr && pp && CMD_WDATA_IN[0] && !PER_PORT_POWER_MASK_IN[2]
        |=> !PORT_POWER_OUT[1])
        else $error("unmasked port 2 not unpowered");
    masked_hold_a: assert property (hub_wr && pp && PER_PORT_POWER_MASK_IN[1] |=> $stable(PORT_POWER_OUT[0]))
        else $error("masked port 1 moved on hub power command");
    irq_pulse_a: assert property (RESUME_DETECTED_IRQ_OUT |=> !RESUME_DETECTED_IRQ_OUT)
        else $error("resume interrupt longer than one cycle");

    cover property (rd_cmd ##1 CMD_RDATA_VALID_OUT);
    cover property (RESUME_DETECTED_IRQ_OUT);
    cover property (hub_wr && pp && PER_PORT_POWER_MASK_IN[2:1] == 2'b11);
endmodule : rhs_root_hub_properties

bind rhs_root_hub rhs_root_hub_properties rhs_root_hub_properties_inst (.*);

// ===== tb/rhs_root_hub_tb.sv
// self-checking bench for the root hub registers
`timescale 1ns/1ps
module rhs_root_hub_tb;
    import rhs_pkg::*;
    logic CLK_SYS_IN = 1'b0;
    logic NRST_IN = 1'b0;
    logic CMD_VALID_IN = 1'b0;
    logic [7:0] CMD_CODE_IN = 8'h00;
    logic [31:0] CMD_WDATA_IN = 32'h0;
    logic [31:0] CMD_RDATA_OUT;
    logic CMD_RDATA_VALID_OUT;
    logic [1:0] DOWNSTREAM_PORT_COUNT_IN = 2'h2;
    logic POWER_SWITCHING_SELECT_IN = 1'b0;
    logic [2:0] PER_PORT_POWER_MASK_IN = 3'h0;
    logic GLOBAL_OC_REPORT_IN = 1'b1;
    logic XFER_BUSY_IN = 1'b0;
    logic USB_SUSPENDED_IN = 1'b0;
    logic [1:0] PORT_CONNECT_IN = 2'h0;
    logic [1:0] PORT_LOW_SPEED_IN = 2'h0;
    logic [1:0] PORT_RESET_DONE_IN = 2'h0;
    logic [1:0] PORT_RESUME_DONE_IN = 2'h0;
    logic RESUME_DETECTED_IRQ_OUT;
    logic [1:0] PORT_OC_N_IN = 2'h3;
    logic [1:0] PORT_POWER_OUT;
    int miscompares = 0;
    int checked = 0;
    int irqs;

    rhs_root_hub rhs_root_hub_inst (.*);

    always #10 CLK_SYS_IN = ~CLK_SYS_IN;

    task automatic close_out;
        if (miscompares == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge CLK_SYS_IN);
        #2;
    endtask : cyc

    // one-cycle command; returns just after the edge that answers it
    task automatic send(input logic [7:0] code, input logic [31:0] data);
        cyc(1);
        CMD_VALID_IN = 1'b1;
        CMD_CODE_IN = code;
        CMD_WDATA_IN = data;
        cyc(1);
        CMD_VALID_IN = 1'b0;
    endtask : send

    task automatic rd(input logic [7:0] code, input logic [31:0] exp);
        send(code, 32'h0);
        chk({31'h0, CMD_RDATA_VALID_OUT}, 32'h1);
        chk(CMD_RDATA_OUT, exp);
    endtask : rd

    // resume interrupt pulses last one cycle, so one sample per cycle counts each once
    task automatic count_irq(input int n);
        irqs = 0;
        repeat (n) begin
            cyc(1);
            if (RESUME_DETECTED_IRQ_OUT === 1'b1) begin
                irqs++;
            end
        end
    endtask : count_irq

    initial begin
        void'($urandom(32'h64f4));
        repeat (6) @(posedge CLK_SYS_IN);
        #2;
        NRST_IN = 1'b1;
        rd(RHS_RD_PORT1, RHS_RESET_VAL);
        rd(RHS_RD_PORT2, RHS_RESET_VAL);
        rd(RHS_RD_HUB, RHS_RESET_VAL);
        for (int i = 0; i < 4; i++) begin
            send({4'h0, 4'($urandom_range(15, 0))}, $urandom);
            chk({31'h0, CMD_RDATA_VALID_OUT}, 32'h0);
        end
        send(RHS_WR_HUB, 32'h0000_8000);
        rd(RHS_RD_HUB, 32'h0000_8000);
        send(RHS_WR_HUB, 32'h0);
        rd(RHS_RD_HUB, 32'h0000_8000);
        send(RHS_WR_HUB, 32'h8000_0000);
        rd(RHS_RD_HUB, 32'h0);
        for (int m = 0; m < 4; m++) begin
            POWER_SWITCHING_SELECT_IN = 1'b0;
            send(RHS_WR_HUB, 32'h1);
            chk({30'h0, PORT_POWER_OUT}, 32'h0);
            POWER_SWITCHING_SELECT_IN = 1'b1;
            PER_PORT_POWER_MASK_IN = {m[1:0], 1'b0};
            send(RHS_WR_HUB, 32'h1_0000);
            chk({30'h0, PORT_POWER_OUT}, {30'h0, ~m[1:0]});
            POWER_SWITCHING_SELECT_IN = 1'b0;
            send(RHS_WR_HUB, 32'h1_0000);
            chk({30'h0, PORT_POWER_OUT}, 32'h3);
            POWER_SWITCHING_SELECT_IN = 1'b1;
            send(RHS_WR_HUB, 32'h1);
            chk({30'h0, PORT_POWER_OUT}, {30'h0, m[1:0]});
        end
        rd(RHS_RD_HUB, 32'h0);
        XFER_BUSY_IN = 1'b1;
        send(RHS_WR_PORT1, 32'h200);
        cyc(4);
        chk({30'h0, PORT_POWER_OUT}, 32'h3);
        XFER_BUSY_IN = 1'b0;
        cyc(3);
        chk({30'h0, PORT_POWER_OUT}, 32'h2);
        rd(RHS_RD_PORT1, 32'h0);
        rd(RHS_RD_PORT2, 32'h100);
        DOWNSTREAM_PORT_COUNT_IN = 2'h1;
        rd(RHS_RD_PORT2, 32'h0);
        cyc(2);
        chk({30'h0, PORT_POWER_OUT}, 32'h0);
        DOWNSTREAM_PORT_COUNT_IN = 2'h2;
        send(RHS_WR_PORT1, 32'h100);
        cyc(2);
        send(RHS_WR_HUB, 32'h8000);
        USB_SUSPENDED_IN = 1'b1;
        PORT_CONNECT_IN = 2'h1;
        count_irq(6);
        chk(32'(irqs), 32'h1);
        rd(RHS_RD_PORT1, 32'h1_0101);
        send(RHS_WR_HUB, 32'h8000_0000);
        PORT_CONNECT_IN = 2'h3;
        count_irq(6);
        chk(32'(irqs), 32'h0);
        PORT_OC_N_IN = 2'h2;
        cyc(5);
        rd(RHS_RD_HUB, 32'h2_0002);
        send(RHS_WR_HUB, 32'h2_0000);
        rd(RHS_RD_HUB, 32'h2);
        PORT_OC_N_IN = 2'h3;
        cyc(5);
        rd(RHS_RD_HUB, 32'h2_0000);
        GLOBAL_OC_REPORT_IN = 1'b0;
        // fault present again, but per-port reporting must keep bit 1 low
        PORT_OC_N_IN = 2'h2;
        cyc(5);
        rd(RHS_RD_HUB, 32'h2_0000);
        close_out();
    end

    // whole sequence needs about 130 cycles
    initial begin
        #100000;
        miscompares++;
        close_out();
    end
endmodule : rhs_root_hub_tb
